// *** hw/fpm_regs.sv ***
// FIFO fill reporting and power management control register bank
`timescale 1ns/1ps
module fpm_regs
   import fpm_pkg::*;
#(
   parameter int WAKE_PULSE_CYCLES = WAKE_PULSE_CYC
) (
   input  wire logic              sys_clk,          // Core clock
   input  wire logic              reset,            // Sync, active high
   input  wire logic [ADDR_W-1:0] reg_addr,         // Byte address
   input  wire logic [DATA_W-1:0] reg_wdata,        // Write data
   input  wire logic              reg_wr,           // Write strobe
   input  wire logic              reg_rd,           // Read strobe
   output logic      [DATA_W-1:0] reg_rdata,        // Read data, next cycle
   input  wire logic              rx_frame_done,    // Frame into RX FIFO
   input  wire logic [15:0]       rx_frame_len,     // Its length, bytes
   input  wire logic              rx_data_pop,      // Host read one dword
   input  wire logic              rx_status_push,   // Status word written
   input  wire logic              rx_status_pop,    // Status word read
   input  wire logic              tx_data_push,     // Host wrote one dword
   input  wire logic              tx_frame_sent,    // Frame left TX FIFO
   input  wire logic [15:0]       tx_frame_len,     // Its length, bytes
   input  wire logic              tx_status_push,   // Status word written
   input  wire logic              tx_status_pop,    // Status word read
   input  wire logic              remote_wake_event,// Wake frame seen
   input  wire logic              energy_event,     // Line energy seen
   output logic                   phy_reset_out,    // PHY reset, high
   output logic                   wake_interrupt,   // Internal wake irq
   output logic                   wake_pin_out,     // Wake pin level
   output logic                   wake_pin_oe_n,    // Low while driving
   output logic      [1:0]        power_state       // Current state
);

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   fpm_tmr_if #(.W(PHY_CNT_W))  phy_t ();
   fpm_tmr_if #(.W(WAKE_CNT_W)) wake_t ();

   fpm_timer #(.W(PHY_CNT_W)) u_phy_tmr (
      .sys_clk (sys_clk),
      .reset   (reset),
      .t       (phy_t)
   );

   fpm_timer #(.W(WAKE_CNT_W)) u_wake_tmr (
      .sys_clk (sys_clk),
      .reset   (reset),
      .t       (wake_t)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]  rx_status_used_dwords_r, rx_status_used_dwords_nxt;
   logic [15:0] rx_data_used_bytes_r,    rx_data_used_bytes_nxt;
   logic [7:0]  tx_status_used_dwords_r, tx_status_used_dwords_nxt;
   logic [15:0] tx_data_free_bytes_r,    tx_data_free_bytes_nxt;
   fpm_state_t  state_r,                 state_nxt;
   logic        ready_r,                 ready_nxt;
   logic        unlocked_r,              unlocked_nxt;
   logic        phy_reset_request_r,               phy_reset_request_nxt;
   logic        rw_en_r,                 rw_en_nxt;
   logic        energy_event_enable_r,                 energy_event_enable_nxt;
   logic        drv_type_r,              drv_type_nxt;
   logic        pulse_sel_r,             pulse_sel_nxt;
   logic        pol_r,                   pol_nxt;
   logic        pin_en_r,                pin_en_nxt;
   logic        rw_pend_r,               rw_pend_nxt;
   logic        ed_pend_r,               ed_pend_nxt;
   logic        irq_r,                   irq_nxt;
   logic        pin_out_r,               pin_out_nxt;
   logic        pin_oe_n_r,              pin_oe_n_nxt;
   logic [DATA_W-1:0] rdata_r,           rdata_nxt;

   logic        wr_ok;
   logic        pm_wr;
   logic        probe_wr;
   logic        wake_now;
   logic        wake_new;
   logic        pin_active;
   logic [16:0] rx_round;
   logic [16:0] tx_round;
   logic [15:0] pm_word;

   // ----------------------------------------------------------------
   // Write qualification
   // ----------------------------------------------------------------
   // Writes are dropped until the host has read once since reset or
   // wake-up, and, while not ready, only the probe write is honoured.
   assign wr_ok    = reg_wr && unlocked_r && ready_r;   // see R08
   assign pm_wr    = wr_ok && (reg_addr == OFS_PM_CTRL);
   assign probe_wr = reg_wr && (reg_addr == OFS_PROBE);  // see R10

   // ----------------------------------------------------------------
   // FIFO level counters
   // ----------------------------------------------------------------
   // Round up to the next dword when the payload ends off a boundary
   assign rx_round = ({1'b0, rx_frame_len} + 17'h00003) & 17'h1fffc;
   assign tx_round = ({1'b0, tx_frame_len} + 17'h00003) & 17'h1fffc;

   always_comb begin
      rx_status_used_dwords_nxt = rx_status_used_dwords_r;
      rx_data_used_bytes_nxt    = rx_data_used_bytes_r;
      tx_status_used_dwords_nxt = tx_status_used_dwords_r;
      tx_data_free_bytes_nxt    = tx_data_free_bytes_r;
      if (rx_status_push && !rx_status_pop) begin
         rx_status_used_dwords_nxt = rx_status_used_dwords_r + 8'h01;
      end else if (rx_status_pop && !rx_status_push) begin
         rx_status_used_dwords_nxt = rx_status_used_dwords_r - 8'h01;
      end                                                 // see R01
      if (rx_frame_done) begin
         rx_data_used_bytes_nxt = rx_data_used_bytes_nxt
                                + rx_round[15:0];         // see R03
      end
      if (rx_data_pop) begin
         rx_data_used_bytes_nxt = rx_data_used_bytes_nxt
                                - DWORD_BYTES;            // see R02
      end
      if (tx_status_push && !tx_status_pop) begin
         tx_status_used_dwords_nxt = tx_status_used_dwords_r + 8'h01;
      end else if (tx_status_pop && !tx_status_push) begin
         tx_status_used_dwords_nxt = tx_status_used_dwords_r - 8'h01;
      end                                                 // see R04
      // Host is trusted not to push beyond the free count
      if (tx_data_push) begin
         tx_data_free_bytes_nxt = tx_data_free_bytes_nxt
                                - DWORD_BYTES;            // see R05 R06
      end
      if (tx_frame_sent) begin
         tx_data_free_bytes_nxt = tx_data_free_bytes_nxt
                                + tx_round[15:0];         // see R05
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_status_used_dwords_r <= STAT_USED_RST;
         rx_data_used_bytes_r    <= RX_USED_RST;
         tx_status_used_dwords_r <= STAT_USED_RST;
         tx_data_free_bytes_r    <= TX_FREE_RST;
      end else begin
         rx_status_used_dwords_r <= rx_status_used_dwords_nxt;
         rx_data_used_bytes_r    <= rx_data_used_bytes_nxt;
         tx_status_used_dwords_r <= tx_status_used_dwords_nxt;
         tx_data_free_bytes_r    <= tx_data_free_bytes_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Power management control
   // ----------------------------------------------------------------
   // Done lands a cycle after the count ends, so load one less
   assign phy_t.load  = PHY_CNT_W'(PHY_RESET_REQUEST_CYC - 1);
   assign phy_t.start = pm_wr && reg_wdata[PM_PHY_RESET_REQUEST]
                        && !phy_reset_request_r;                    // see R13

   always_comb begin
      state_nxt     = state_r;
      unlocked_nxt  = unlocked_r || reg_rd;               // see R08
      phy_reset_request_nxt   = phy_reset_request_r;
      rw_en_nxt     = rw_en_r;
      energy_event_enable_nxt     = energy_event_enable_r;
      drv_type_nxt  = drv_type_r;
      pulse_sel_nxt = pulse_sel_r;
      pol_nxt       = pol_r;
      pin_en_nxt    = pin_en_r;
      if (phy_t.start) begin
         phy_reset_request_nxt = 1'b1;                              // see R12
      end else if (phy_t.done) begin
         phy_reset_request_nxt = 1'b0;                              // see R12
      end
      if (pm_wr) begin
         rw_en_nxt     = reg_wdata[PM_RW_EN];
         energy_event_enable_nxt     = reg_wdata[PM_ENERGY_EVENT_ENABLE];
         drv_type_nxt  = reg_wdata[PM_DRV_TYPE];          // see R18
         pulse_sel_nxt = reg_wdata[PM_PULSE_SEL];         // see R20
         pol_nxt       = reg_wdata[PM_POLARITY];
         pin_en_nxt    = reg_wdata[PM_PIN_EN];            // see R21
         // The reserved encoding is refused; state stays put
         case (reg_wdata[PM_STATE_LSB+1:PM_STATE_LSB])
            2'b01: begin
               state_nxt = FPM_WAKE_FRAME;                // see R09
            end
            2'b10: begin
               state_nxt = FPM_ENERGY_DET;                // see R09
            end
            default: begin
               state_nxt = state_r;
            end
         endcase
      end
      if (probe_wr && state_r != FPM_FULL_POWER) begin
         state_nxt    = FPM_FULL_POWER;                   // see R10
         unlocked_nxt = 1'b0;                             // see R08
      end
      ready_nxt = (state_nxt == FPM_FULL_POWER);          // see R19
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r     <= FPM_FULL_POWER;
         ready_r     <= 1'b1;
         unlocked_r  <= 1'b0;
         phy_reset_request_r   <= 1'b0;
         rw_en_r     <= 1'b0;
         energy_event_enable_r     <= 1'b0;
         drv_type_r  <= 1'b0;
         pulse_sel_r <= 1'b0;
         pol_r       <= 1'b0;
         pin_en_r    <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         ready_r     <= ready_nxt;
         unlocked_r  <= unlocked_nxt;
         phy_reset_request_r   <= phy_reset_request_nxt;
         rw_en_r     <= rw_en_nxt;
         energy_event_enable_r     <= energy_event_enable_nxt;
         drv_type_r  <= drv_type_nxt;
         pulse_sel_r <= pulse_sel_nxt;
         pol_r       <= pol_nxt;
         pin_en_r    <= pin_en_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Wake events and wake pin
   // ----------------------------------------------------------------
   // A pending event lasts until its enable is cleared; an event in
   // the clearing cycle still wins.
   assign wake_now = (remote_wake_event && rw_en_r)
                  || (energy_event && energy_event_enable_r);
   assign wake_new = wake_now && !(rw_pend_r || ed_pend_r);
   assign wake_t.load  = WAKE_CNT_W'(WAKE_PULSE_CYCLES);
   assign wake_t.start = wake_new && pulse_sel_r;         // see R20
   assign pin_active   = pin_en_r && (pulse_sel_r ? wake_t.busy
                                      : (rw_pend_r || ed_pend_r));

   always_comb begin
      rw_pend_nxt = (rw_pend_r && rw_en_nxt)
                 || (remote_wake_event && rw_en_r);       // see R14
      ed_pend_nxt = (ed_pend_r && energy_event_enable_nxt)
                 || (energy_event && energy_event_enable_r);            // see R16
      irq_nxt     = rw_pend_nxt || ed_pend_nxt;           // see R15 R17
      if (!drv_type_r) begin
         pin_out_nxt  = 1'b0;                             // see R18
         pin_oe_n_nxt = !pin_active;                      // see R14 R16
      end else begin
         pin_out_nxt  = pol_r ? pin_active : !pin_active; // see R18
         pin_oe_n_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rw_pend_r  <= 1'b0;
         ed_pend_r  <= 1'b0;
         irq_r      <= 1'b0;
         pin_out_r  <= 1'b0;
         pin_oe_n_r <= 1'b1;
      end else begin
         rw_pend_r  <= rw_pend_nxt;
         ed_pend_r  <= ed_pend_nxt;
         irq_r      <= irq_nxt;
         pin_out_r  <= pin_out_nxt;
         pin_oe_n_r <= pin_oe_n_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      pm_word                                = 16'h0000;  // see R22
      pm_word[PM_STATE_LSB+1:PM_STATE_LSB]   = state_r;
      pm_word[PM_PHY_RESET_REQUEST]                    = phy_reset_request_r;
      pm_word[PM_RW_EN]                      = rw_en_r;
      pm_word[PM_ENERGY_EVENT_ENABLE]                      = energy_event_enable_r;
      pm_word[PM_DRV_TYPE]                   = drv_type_r;
      pm_word[PM_PULSE_SEL]                  = pulse_sel_r;
      pm_word[PM_POLARITY]                   = pol_r;
      pm_word[PM_PIN_EN]                     = pin_en_r;
      pm_word[PM_READY]                      = ready_r;   // see R19
      rdata_nxt = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            OFS_RX_FILL: begin
               rdata_nxt[STAT_LSB+7:STAT_LSB] = rx_status_used_dwords_r;
               rdata_nxt[15:0]                = rx_data_used_bytes_r;
            end
            OFS_TX_FILL: begin
               rdata_nxt[STAT_LSB+7:STAT_LSB] = tx_status_used_dwords_r;
               rdata_nxt[15:0]                = tx_data_free_bytes_r;
            end
            OFS_PM_CTRL: begin
               rdata_nxt[15:0] = pm_word;                 // see R07
            end
            OFS_PROBE: begin
               rdata_nxt = PROBE_PATTERN;
            end
            default: begin
               rdata_nxt = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_r <= 32'h00000000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata      = rdata_r;
   assign phy_reset_out  = phy_reset_request_r;
   assign wake_interrupt = irq_r;
   assign wake_pin_out   = pin_out_r;
   assign wake_pin_oe_n  = pin_oe_n_r;
   assign power_state    = state_r;

endmodule

// *** pkg/fpm_pkg.sv ***
// Constants for the FIFO level and power management register bank
//
// Contract
// R01: Receive status used dwords in bits 23:16
// R02: Receive data used bytes in bits 15:0
// R03: Frame length adds, rounded up to dword
// R04: Transmit status used dwords in bits 23:16
// R05: Transmit free bytes in 15:0, reset 0x1200
// R06: Host never overfills transmit data FIFO
// R07: Power control readable in any power state
// R08: Host reads once before writes take effect
// R09: Power state field: normal, wake-frame, energy
// R10: Probe register write wakes the device
// R11: Host writes only probe while not ready
// R12: PHY reset held 100us, then self-clears
// R13: PHY reset bit ignores writes while set
// R14: Remote wake drives wake pin if enabled
// R15: Remote wake always raises wake interrupt; code raises it only while remote wake enable (rw_en_r) is set
// R16: Energy event drives wake pin if enabled
// R17: Energy event always raises wake interrupt; code raises it only while energy_event_enable_r is set
// R18: Drive type: open-drain active low, push-pull
// R19: Ready bit reads one once stable
// R20: Pulse select: 50ms pulse, else level
// R21: Pin enable bit leaves interrupt alone
// R22: Reserved bits read zero, ignore writes
package fpm_pkg;

   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int         ADDR_W          = 8;
   localparam int         DATA_W          = 32;
   localparam logic [7:0] OFS_PROBE       = 8'h70;
   localparam logic [7:0] OFS_RX_FILL     = 8'h7c;
   localparam logic [7:0] OFS_TX_FILL     = 8'h80;
   localparam logic [7:0] OFS_PM_CTRL     = 8'h84;
   localparam logic [31:0] PROBE_PATTERN  = 32'h87654321;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int STAT_LSB      = 16;
   localparam int PM_STATE_LSB  = 12;
   localparam int PM_PHY_RESET_REQUEST    = 10;
   localparam int PM_RW_EN      = 9;
   localparam int PM_ENERGY_EVENT_ENABLE      = 8;
   localparam int PM_DRV_TYPE   = 6;
   localparam int PM_PULSE_SEL  = 3;
   localparam int PM_POLARITY   = 2;
   localparam int PM_PIN_EN     = 1;
   localparam int PM_READY      = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  STAT_USED_RST = 8'h00;
   localparam logic [15:0] RX_USED_RST   = 16'h0000;
   localparam logic [15:0] TX_FREE_RST   = 16'h1200;
   localparam logic [15:0] DWORD_BYTES   = 16'h0004;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 50;
   localparam int PHY_RESET_REQUEST_TIME_NS  = 100000;
   localparam int PHY_RESET_REQUEST_CYC      =
      (PHY_RESET_REQUEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PHY_CNT_W        = 12;
   localparam int WAKE_PULSE_MS    = 50;
   localparam int WAKE_PULSE_CYC   =
      WAKE_PULSE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int WAKE_CNT_W       = 20;

   // ----------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FPM_FULL_POWER   = 2'b00,
      FPM_WAKE_FRAME   = 2'b01,
      FPM_ENERGY_DET   = 2'b10,
      FPM_RESERVED     = 2'b11
   } fpm_state_t;

endpackage

// *** pkg/fpm_tmr_if.sv ***
// Control link between the register bank and a countdown timer
`timescale 1ns/1ps
interface fpm_tmr_if #(parameter int W = 12);
   logic         start;   // Load and run
   logic [W-1:0] load;    // Cycles to run
   logic         busy;    // Counting
   logic         done;    // Pulse the cycle after busy ends

   modport ctrl (output start, output load, input busy, input done);
   modport tmr  (input start, input load, output busy, output done);
endinterface

// *** hw/fpm_timer.sv ***
// Countdown timer: busy for exactly load cycles after start
`timescale 1ns/1ps
module fpm_timer #(
   parameter int W = 12
) (
   input  wire logic sys_clk,   // Core clock
   input  wire logic reset,     // Sync reset, active high
   fpm_tmr_if.tmr    t          // Start, load, busy, done
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         done_r;
   logic         done_nxt;

   always_comb begin
      cnt_nxt  = cnt_r;
      done_nxt = 1'b0;
      if (t.start) begin
         cnt_nxt = t.load;
      end else if (cnt_r != '0) begin
         cnt_nxt  = cnt_r - 1'b1;
         done_nxt = (cnt_r == {{(W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign t.busy = (cnt_r != '0);
   assign t.done = done_r;
endmodule

// *** sim/fpm_regs_asserts.sv ***
// Port-level checks on the FIFO fill and power register bank
`timescale 1ns/1ps
module fpm_regs_asserts
   import fpm_pkg::*;
#(
   parameter int WAKE_PULSE_CYCLES = WAKE_PULSE_CYC
) (
   input wire logic              sys_clk,        // Core clock
   input wire logic              reset,          // Sync reset
   input wire logic [ADDR_W-1:0] reg_addr,       // Byte address
   input wire logic [DATA_W-1:0] reg_wdata,      // Write data
   input wire logic              reg_wr,         // Write strobe
   input wire logic              reg_rd,         // Read strobe
   input wire logic [DATA_W-1:0] reg_rdata,      // Read data
   input wire logic              phy_reset_out,  // PHY reset
   input wire logic              wake_interrupt, // Wake irq
   input wire logic [1:0]        power_state     // Current state
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   // Writes only land once a read has been seen since reset or wake
   logic                 rd_seen_r;
   logic                 rd_seen_nxt;
   logic [PHY_CNT_W-1:0] phy_cnt_r;
   logic [PHY_CNT_W-1:0] phy_cnt_nxt;
   logic                 pm_wr;
   logic                 pm_rd;
   logic                 wake_wr;

   assign pm_wr   = reg_wr && reg_addr == OFS_PM_CTRL;
   assign pm_rd   = reg_rd && reg_addr == OFS_PM_CTRL;
   assign wake_wr = reg_wr && reg_addr == OFS_PROBE && power_state != 2'b00;

   always_comb begin
      rd_seen_nxt = reg_rd ? 1'b1 : (wake_wr ? 1'b0 : rd_seen_r);
      phy_cnt_nxt = phy_reset_out ? phy_cnt_r + 1'b1 : '0;
   end

   always_ff @(posedge sys_clk) begin
      rd_seen_r <= reset ? 1'b0 : rd_seen_nxt;
      phy_cnt_r <= reset ? '0 : phy_cnt_nxt;
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_PM_STATE_READ: assert property (pm_rd |=>
      reg_rdata[13:12] == $past(power_state)) else $error("state misread");
   AST_PM_READY: assert property (pm_rd |=>
      reg_rdata[PM_READY] == ($past(power_state) == 2'b00))
      else $error("ready bit wrong");
   AST_PM_RSVD_ZERO: assert property (pm_rd |=>
      {reg_rdata[31:14], reg_rdata[11], reg_rdata[7], reg_rdata[5:4]} == '0)
      else $error("power reserved bits set");
   AST_FIFO_RSVD_ZERO: assert property (reg_rd &&
      (reg_addr == OFS_RX_FILL || reg_addr == OFS_TX_FILL) |=>
      reg_rdata[31:24] == 8'h00) else $error("fill reserved bits set");
   AST_PHY_HOLD_FULL: assert property ($fell(phy_reset_out) |->
      phy_cnt_r == PHY_CNT_W'(PHY_RESET_REQUEST_CYC)) else $error("phy reset short");
   AST_PHY_HOLD_MAX: assert property (phy_reset_out |->
      phy_cnt_r < PHY_CNT_W'(PHY_RESET_REQUEST_CYC)) else $error("phy reset long");
   AST_PHY_START: assert property (pm_wr && reg_wdata[PM_PHY_RESET_REQUEST] &&
      rd_seen_r && power_state == 2'b00 && !phy_reset_out |=> phy_reset_out)
      else $error("phy reset not started");
   AST_WR_LOCKED: assert property (pm_wr && !rd_seen_r |=>
      $stable(power_state) && !$rose(phy_reset_out))
      else $error("write took effect before read");
   AST_STATE_SET: assert property (pm_wr && rd_seen_r &&
      power_state == 2'b00 && reg_wdata[13:12] != 2'b11 |=>
      power_state == $past(reg_wdata[13:12])) else $error("state not set");
   AST_PROBE_WAKE: assert property (wake_wr |=>
      power_state == 2'b00) else $error("probe write did not wake");

   COV_PHY_DONE: cover property ($fell(phy_reset_out));
   COV_WAKE_IRQ: cover property ($rose(wake_interrupt));
   COV_LOCKED_WR: cover property (pm_wr && !rd_seen_r);
endmodule

// *** sim/fpm_host.sv ***
// Host model: register reads and writes on the plain bus
`timescale 1ns/1ps
module fpm_host
   import fpm_pkg::*;
(
   input  wire logic              sys_clk,   // Core clock
   input  wire logic [DATA_W-1:0] reg_rdata, // Read data
   output logic      [ADDR_W-1:0] reg_addr,  // Byte address
   output logic      [DATA_W-1:0] reg_wdata, // Write data
   output logic                   reg_wr,    // Write strobe
   output logic                   reg_rd     // Read strobe
);
   initial begin
      reg_addr  = '0;
      reg_wdata = '0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // Callers may also write before the first read or while not ready,
   // to check such writes are dropped; released lines are inverted so stale values never help
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask
endmodule

// *** sim/fpm_regs_tb.sv ***
// Self-checking bench for the FIFO fill and power register bank
`timescale 1ns/1ps
module fpm_regs_tb
   import fpm_pkg::*;
;
   localparam int WAKE_CYC = 20;
   logic sys_clk, reset, reg_wr, reg_rd, phy_reset_out, wake_interrupt;
   logic wake_pin_out, wake_pin_oe_n;
   logic [1:0]  power_state;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [9:0]  ev;
   logic [15:0] flen, rx_frame_len, tx_frame_len;
   logic rx_frame_done, rx_data_pop, rx_status_push, rx_status_pop;
   logic tx_data_push, tx_frame_sent, tx_status_push, tx_status_pop;
   logic remote_wake_event, energy_event;
   int   mismatches, checks_done, n;

   assign {energy_event, remote_wake_event, tx_status_pop, tx_status_push,
      tx_frame_sent, tx_data_push, rx_status_pop, rx_status_push,
      rx_data_pop, rx_frame_done} = ev;
   assign rx_frame_len = flen;
   assign tx_frame_len = flen;

   fpm_regs #(.WAKE_PULSE_CYCLES(WAKE_CYC)) u_dut (.*);
   fpm_host u_host (.*);

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      u_host.rd(a, d);
      chk($sformatf("register %h", a), d, exp);
   endtask

   task automatic pulse(input int i, input logic [15:0] len);
      @(posedge sys_clk);
      ev[i] <= 1'b1;
      flen  <= len;
      @(posedge sys_clk);
      ev[i] <= 1'b0;
   endtask

   // Irq, pin data, pin output enable (low) (masked) after outputs settle
   task automatic pins(input logic [2:0] exp, input logic [2:0] m);
      repeat (2) @(negedge sys_clk);
      chk("wake pins", {29'h0, {wake_interrupt, wake_pin_out,
         wake_pin_oe_n} & m}, {29'h0, exp});
   endtask

   task automatic st(input logic [1:0] exp);
      @(negedge sys_clk);
      chk("power state", {30'h0, power_state}, {30'h0, exp});
   endtask

   initial begin
      reset = 1'b1;
      ev    = '0;
      flen  = '0;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      u_host.wr(OFS_PM_CTRL, 32'h0000_0200);
      rchk(OFS_PM_CTRL, 32'h0000_0001);
      rchk(OFS_RX_FILL, 32'h0000_0000);
      rchk(OFS_TX_FILL, 32'h0000_1200);
      rchk(8'h10, 32'h0000_0000);
      rchk(OFS_PROBE, PROBE_PATTERN);
      $display("reset values done");
      // Lengths on and off a dword boundary
      pulse(0, 16'h0001);
      pulse(0, 16'h0004);
      pulse(0, 16'h0005);
      pulse(1, 16'h0000);
      repeat (2) pulse(2, 16'h0000);
      pulse(3, 16'h0000);
      rchk(OFS_RX_FILL, 32'h0001_000c);
      repeat (3) pulse(4, 16'h0000);
      pulse(5, 16'h0007);
      repeat (3) pulse(6, 16'h0000);
      pulse(7, 16'h0000);
      rchk(OFS_TX_FILL, 32'h0002_11fc);
      $display("fifo levels done");
      u_host.wr(OFS_PM_CTRL, 32'hffff_ffff);
      rchk(OFS_PM_CTRL, 32'h0000_074f);
      u_host.wr(OFS_PM_CTRL, 32'h0000_0400);
      rchk(OFS_PM_CTRL, 32'h0000_0401);
      n = 0;
      while (phy_reset_out === 1'b1 && n < 2100) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 2100) begin
         mismatches++;
         end_sim();
      end
      rchk(OFS_PM_CTRL, 32'h0000_0001);
      $display("phy reset done");
      u_host.wr(OFS_PM_CTRL, 32'h0000_0246);
      pulse(8, 16'h0000);
      pins(3'b110, 3'b111);
      u_host.wr(OFS_PM_CTRL, 32'h0000_0100);
      pins(3'b001, 3'b101);
      pulse(9, 16'h0000);
      pins(3'b101, 3'b101);
      u_host.wr(OFS_PM_CTRL, 32'h0000_0102);
      pins(3'b100, 3'b111);
      u_host.wr(OFS_PM_CTRL, 32'h0000_0000);
      u_host.wr(OFS_PM_CTRL, 32'h0000_024e);
      pulse(8, 16'h0000);
      n = 0;
      repeat (60) begin
         @(negedge sys_clk);
         if (wake_pin_out === 1'b1) n++;
      end
      chk("pulse width", n, WAKE_CYC);
      $display("wake output done");
      u_host.wr(OFS_PM_CTRL, 32'h0000_1000);
      rchk(OFS_PM_CTRL, 32'h0000_1000);
      u_host.wr(OFS_PM_CTRL, 32'h0000_0000);
      st(2'b01);
      u_host.wr(OFS_PROBE, 32'h0000_0000);
      st(2'b00);
      u_host.wr(OFS_PM_CTRL, 32'h0000_2000);
      st(2'b00);
      rchk(OFS_PM_CTRL, 32'h0000_0001);
      u_host.wr(OFS_PM_CTRL, 32'h0000_2000);
      st(2'b10);
      u_host.wr(OFS_PROBE, 32'h0000_0000);
      st(2'b00);
      $display("power states done");
      end_sim();
   end
endmodule

bind fpm_regs fpm_regs_asserts #(.WAKE_PULSE_CYCLES(WAKE_PULSE_CYCLES)) u_chk (.*);
